// ### design/glp_port.sv
`timescale 1ns/1ps
module glp_port
  import glp_pkg::*;
#(
  parameter int BLINK_CYC = GLP_BLINK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire glp_cfg_t cfg_i,
  input wire glp_link_t link_i,
  input wire logic [GLP_PINS-1:0] pin_i,
  output logic [GLP_PINS-1:0] pin_o,
  output logic [GLP_PINS-1:0] pin_oe_n_o,
  output logic [GLP_PINS-1:0] pin_in_o,
  output logic speed_lamp_n_o,
  output logic link_activity_lamp_n_o,
  output logic duplex_lamp_n_o
);

  logic [GLP_PINS-1:0] sync_a;
  logic [GLP_PINS-1:0] sync_b;
  logic [GLP_PINS-1:0] lamp_n;
  logic [GLP_PINS-1:0] next_pin;
  logic [GLP_PINS-1:0] next_oe_n;

  // pin pads are asynchronous: three flops from pin_i to pin_in_o
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync_a <= GLP_OUT_RST;
      sync_b <= GLP_OUT_RST;
      pin_in_o <= GLP_OUT_RST;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      pin_in_o <= sync_b;
    end
  end

  // speed lamp high only at 10M with link up and no negotiation
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      speed_lamp_n_o <= 1'b0;
    end else begin
      speed_lamp_n_o <= link_i.link_up && !link_i.speed_100
                        && !link_i.autoneg_busy;
    end
  end

  // activity blink timing; a bench may shorten the 80 ms span here
  glp_blink #(
    .BLINK_CYC(BLINK_CYC)
  ) u_blink (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .link_up_i(link_i.link_up),
    .activity_i(link_i.tx_act || link_i.rx_act),
    .lamp_n_o(link_activity_lamp_n_o)
  );

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      duplex_lamp_n_o <= 1'b1;
    end else begin
      duplex_lamp_n_o <= !link_i.full_duplex;
    end
  end

  assign lamp_n = {duplex_lamp_n_o, link_activity_lamp_n_o, speed_lamp_n_o};

  function automatic logic [1:0] glp_drive(input glp_dir_t dir, input logic val);
    logic [1:0] r;
    r = 2'h1;
    unique case (dir)
      GLP_DIR_PUSH: r = {val, 1'b0};
      GLP_DIR_DRAIN: r = {1'b0, val};
      default: r = 2'h1;
    endcase
    return r;
  endfunction : glp_drive

  // per-pin output mux; returns {level, oe_n}
  always_comb begin
    next_pin = GLP_OUT_RST;
    next_oe_n = {GLP_PINS{1'b1}};
    for (int i = 0; i < GLP_PINS; i++) begin
      if (cfg_i.lamp_sel[i]) begin
        {next_pin[i], next_oe_n[i]} = glp_drive(GLP_DIR_DRAIN, lamp_n[i]);
      end else begin
        {next_pin[i], next_oe_n[i]} = glp_drive(cfg_i.dir[i], cfg_i.out_val[i]);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_o <= GLP_OUT_RST;
      pin_oe_n_o <= {GLP_PINS{1'b1}};
    end else begin
      pin_o <= next_pin;
      pin_oe_n_o <= next_oe_n;
    end
  end

endmodule : glp_port

// ### design/glp_pkg.sv
package glp_pkg;

  localparam int GLP_PINS = 3;
  localparam int GLP_CLK_HZ = 50_000_000;
  localparam int GLP_BLINK_MS = 80;
  localparam int GLP_BLINK_CYC = GLP_CLK_HZ / 1000 * GLP_BLINK_MS;
  localparam int GLP_CNT_W = 23;
  localparam logic [GLP_CNT_W-1:0] GLP_CNT_RST = 23'h000000;
  localparam logic [GLP_PINS-1:0] GLP_OUT_RST = 3'h0;
  localparam logic [1:0] GLP_SYNC_RST = 2'h0;

  // per-pin direction and driver type
  typedef enum logic [1:0] {
    GLP_DIR_IN = 2'h0,
    GLP_DIR_PUSH = 2'h1,
    GLP_DIR_DRAIN = 2'h2
  } glp_dir_t;

  // pin 0 speed lamp, pin 1 link/activity lamp, pin 2 duplex lamp
  typedef struct packed {
    glp_dir_t [GLP_PINS-1:0] dir;
    logic [GLP_PINS-1:0] lamp_sel;
    logic [GLP_PINS-1:0] out_val;
  } glp_cfg_t;

  typedef struct packed {
    logic speed_100;
    logic link_up;
    logic full_duplex;
    logic autoneg_busy;
    logic tx_act;
    logic rx_act;
  } glp_link_t;

endpackage : glp_pkg

// ### design/glp_blink.sv
`timescale 1ns/1ps
module glp_blink
  import glp_pkg::*;
#(
  parameter int BLINK_CYC = GLP_BLINK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic link_up_i,
  input wire logic activity_i,
  output logic lamp_n_o
);

  typedef enum logic [1:0] {GLP_IDLE, GLP_OFF, GLP_ON_HOLD} glp_blink_st_t;

  glp_blink_st_t state;
  logic [GLP_CNT_W-1:0] cnt;
  logic cnt_done;

  assign cnt_done = (cnt == GLP_CNT_W'(BLINK_CYC - 1));

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= GLP_IDLE;
      cnt <= GLP_CNT_RST;
    end else begin
      unique case (state)
        GLP_IDLE: begin
          cnt <= GLP_CNT_RST;
          if (activity_i) begin
            state <= GLP_OFF;
          end
        end
        GLP_OFF: begin
          cnt <= cnt_done ? GLP_CNT_RST : cnt + 1'b1;
          if (cnt_done) begin
            state <= GLP_ON_HOLD;
          end
        end
        GLP_ON_HOLD: begin
          cnt <= cnt_done ? GLP_CNT_RST : cnt + 1'b1;
          if (cnt_done) begin
            state <= GLP_IDLE;
          end
        end
      endcase
    end
  end

  // lamp on while link valid and not in off pulse
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lamp_n_o <= 1'b1;
    end else begin
      lamp_n_o <= !(link_up_i && !(state == GLP_OFF));
    end
  end

endmodule : glp_blink

// ### testbench/glp_port_properties.sv
`timescale 1ns/1ps
module glp_chk
  import glp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire glp_cfg_t cfg_i,
  input wire glp_link_t link_i,
  input wire logic [2:0] pin_i,
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe_n_o,
  input wire logic [2:0] pin_in_o,
  input wire logic speed_lamp_n_o,
  input wire logic link_activity_lamp_n_o,
  input wire logic duplex_lamp_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [1:0] up;
  wire go = up != 2'h0;
  wire [2:0] lm = {duplex_lamp_n_o, link_activity_lamp_n_o, speed_lamp_n_o};
  // cycles since reset, so no check looks back into the reset
  always_ff @(posedge clk_sys_i) up <= sys_rst_i ? 2'h0 : up + 2'(up != 2'h3);
  spd_lamp_a: assert property (go |-> speed_lamp_n_o == $past(link_i.link_up &
    !link_i.speed_100 & !link_i.autoneg_busy)) else $error("speed lamp");
  dup_lamp_a: assert property (go |-> duplex_lamp_n_o != $past(link_i.full_duplex))
    else $error("duplex lamp");
  link_off_a: assert property (go && !$past(link_i.link_up) |-> link_activity_lamp_n_o)
    else $error("link lamp");
  in_sync_a: assert property (up == 2'h3 |-> pin_in_o == $past(pin_i, 3))
    else $error("pin input");
  for (genvar i = 0; i < 3; i++) begin : g_pin
    wire gp = !cfg_i.lamp_sel[i];
    lamp_pin_a: assert property (go && $past(!gp) |-> !pin_o[i] &&
      pin_oe_n_o[i] == $past(lm[i])) else $error("lamp pin");
    push_pin_a: assert property (go && $past(gp && cfg_i.dir[i] == GLP_DIR_PUSH) |->
      !pin_oe_n_o[i] && pin_o[i] == $past(cfg_i.out_val[i])) else $error("push pin");
    drain_pin_a: assert property (go && $past(gp && cfg_i.dir[i] == GLP_DIR_DRAIN) |->
      pin_oe_n_o[i] == $past(cfg_i.out_val[i]) && (pin_oe_n_o[i] || !pin_o[i])) else $error("drain");
    in_pin_a: assert property (go && $past(gp && cfg_i.dir[i] == GLP_DIR_IN) |->
      pin_oe_n_o[i]) else $error("input pin");
  end
  spd_c: cover property (speed_lamp_n_o);
  act_c: cover property ($rose(link_activity_lamp_n_o) && link_i.link_up);
  lamp_c: cover property (cfg_i.lamp_sel == 3'h7);
endmodule : glp_chk
bind glp_port glp_chk chk (.*);

// ### testbench/glp_pads.sv
`timescale 1ns/1ps
module glp_pads (
  input wire logic [2:0] drv_i,
  input wire logic [2:0] oe_n_i,
  input wire logic [2:0] pull_i,
  output logic [2:0] pad_o
);
  // released pads settle at the board pull level
  assign pad_o = (~oe_n_i & drv_i) | (oe_n_i & pull_i);
endmodule : glp_pads

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import glp_pkg::*;
;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, spd, lnk, dup;
  logic [2:0] pad, po, oe, din;
  glp_cfg_t cfg = '0, cv[4] = '{12'h545, 12'hA83, 12'h0C0, 12'h57D};
  glp_link_t lk = '0;
  logic [2:0] pv[4] = '{3'h5, 3'h3, 3'h7, 3'h5};
  int error_cnt = 0, num_checks = 0, c;
  always #10 clk_sys_i = ~clk_sys_i;
  glp_port #(.BLINK_CYC(8)) dut (.clk_sys_i, .sys_rst_i, .cfg_i(cfg), .link_i(lk), .pin_i(pad),
    .pin_o(po),
    .pin_oe_n_o(oe), .pin_in_o(din), .speed_lamp_n_o(spd), .link_activity_lamp_n_o(lnk),
    .duplex_lamp_n_o(dup));
  // lamp pins are pulled up on the board, so a released lamp reads high
  glp_pads pads (.drv_i(po), .oe_n_i(oe), .pull_i(3'h7), .pad_o(pad));
  task chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, e, g);
    end
  endtask : chk
  task cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task run(logic v);
    for (c = 0; lnk === v && c < 40; c++) cyc(1);
  endtask : run
  task conclude();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    cyc(4);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      lk = glp_link_t'(6'(i * 4));
      cyc(1);
      chk("speed", 8'(i == 4 || i == 6), 8'(spd));
      chk("link dup", {6'h0, !i[1], !i[2]}, {6'h0, dup, lnk});
    end
    // link up at 10M half duplex: speed and duplex lamps released, link lamp driven
    lk = glp_link_t'(6'h10);
    foreach (cv[k]) begin
      cfg = cv[k];
      cyc(5);
      chk("pin", 8'(pv[k]), 8'(k == 2 ? din : pad));
    end
    lk.tx_act = 1'b1;
    cyc(1);
    lk.tx_act = 1'b0;
    cyc(1);
    chk("act", 8'h01, 8'(lnk));
    run(1'b1);
    chk("off", 8'h08, 8'(c));
    lk.rx_act = 1'b1;
    cyc(1);
    lk.rx_act = 1'b0;
    run(1'b0);
    chk("refused", 8'h28, 8'(c));
    lk.tx_act = 1'b1;
    run(1'b0);
    run(1'b1);
    run(1'b0);
    chk("hold", 8'h01, 8'(c > 7 && c < 12));
    conclude();
  end
  initial begin
    cyc(2000);
    error_cnt++;
    conclude();
  end
endmodule : testbench
